// ===== bench/spdb_peer.sv
// remote serial peer: drives rxd and captures frames from txd
`timescale 1ns/10ps
module spdb_peer #(
  parameter int BT = 4  // clocks per bit, baud plus one
) (
  input  wire logic clk,
  input  wire logic txd,
  output logic      rxd
);
  initial rxd = 1'b1;  // line idles high between frames
  // nb bits of f go out lsb first, then the line idles one bit time so
  // that a bad stop bit never merges into the next start bit
  task automatic send(input logic [11:0] f, input int nb);
    for (int i = 0; i < nb; i++) begin
      rxd <= f[i];
      repeat (BT) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (BT) @(posedge clk);
  endtask
  // sample mid-bit; the first stop bit lands in bit 9
  task automatic get(output logic [9:0] d, input int n);
    d = '0;
    while (txd !== 1'b0) @(posedge clk);
    repeat (BT / 2) @(posedge clk);
    for (int i = 0; i <= n; i++) begin
      repeat (BT) @(posedge clk);
      d[(i == n) ? 9 : i] = txd;
    end
  endtask
endmodule

// ===== bench/spdb_tb.sv
// self-checking bench for the serial port data buffers
`timescale 1ns/10ps
module tb;
  localparam int BT = 4;  // baud 3 keeps each bit to four clocks
  localparam logic [7:0] RXL = spdb_pkg::IDX_RXL;
  localparam logic [7:0] RXH = spdb_pkg::IDX_RXH;
  localparam logic [7:0] TXL = spdb_pkg::IDX_TXL;
  localparam logic [7:0] STA = spdb_pkg::IDX_STATUS;
  localparam logic [7:0] CB  = spdb_pkg::IDX_ENABLE_AND_RECEIVE_MODE_CONTROL;
  localparam logic [7:0] CC  = spdb_pkg::IDX_FRAME_FORMAT_CONTROL;
  logic        clk = 0, nrst = 0, hsel = 1, hwrite = 0;
  logic        txd, rxd, hreadyout, hresp;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [9:0]  fr;
  int          fail_count = 0, compares = 0, cyc = 0;
  always #2 clk = ~clk;
  spdb_top DUT (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rxd(rxd), .txd(txd));
  spdb_peer #(.BT(BT)) peer (.clk(clk), .txd(txd), .rxd(rxd));
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one single ahb transfer; waits on ready, never on a fixed count
  task automatic bus(input logic wr, input logic [7:0] idx, wd,
                     output logic [31:0] rd);
    @(posedge clk);
    htrans <= 2'h2;
    haddr  <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, wd);
    logic [31:0] d;
    bus(1'b1, idx, wd, d);
  endtask
  task automatic rc(input logic [7:0] idx, e);
    logic [31:0] d;
    bus(1'b0, idx, 8'h00, d);
    chk($sformatf("reg %h", idx), d, {24'h0, e});
  endtask
  task automatic t_reset;
    rc(STA, 8'h20);
    rc(RXH, 8'h00);
    rc(8'h3f, 8'h00);
  endtask
  // two stored, one waiting with a bad stop bit, a fourth start
  task automatic t_overrun;
    wr(spdb_pkg::IDX_BAUDL, 8'h03);
    wr(CC, 8'h03);
    wr(CB, 8'h80);
    peer.send({3'h7, 8'h11, 1'b0}, 10);
    peer.send({3'h7, 8'h22, 1'b0}, 10);
    peer.send({3'h6, 8'h3c, 1'b0}, 10);
    peer.send({3'h7, 8'h44, 1'b0}, 10);
    rc(RXH, 8'h80);
    rc(RXL, 8'h11);
    rc(RXH, 8'h80);
    rc(RXL, 8'h22);
    rc(RXH, 8'hc4);
    rc(RXL, 8'h3c);
    rc(RXH, 8'h00);
  endtask
  // even parity, wrong parity bit sent, then receiver disabled
  task automatic t_parity;
    wr(CC, 8'h23);
    peer.send({2'h3, 1'b0, 8'h01, 1'b0}, 11);
    rc(RXH, 8'h82);
    wr(CB, 8'h00);
    rc(STA, 8'h20);
    rc(RXH, 8'h00);
  endtask
  task automatic t_short;
    wr(CC, 8'h00);
    wr(CB, 8'hc0);
    peer.send({5'h1f, 1'b1, 5'h15, 1'b0}, 7);
    rc(RXH, 8'h80);
    rc(RXL, 8'h15);
    wr(TXL, 8'hf5);
    peer.get(fr, 5);
    chk("tx frame", {22'h0, fr}, 32'h0000_0215);
    repeat (2 * BT) @(posedge clk);
  endtask
  // third write lands while the buffer is full and must vanish
  task automatic t_tx;
    wr(STA, 8'h40);
    wr(CC, 8'h03);
    fork
      begin
        peer.get(fr, 8);
        chk("tx frame", {22'h0, fr}, 32'h0000_02a5);
        peer.get(fr, 8);
        chk("tx frame", {22'h0, fr}, 32'h0000_023c);
      end
      begin
        wr(TXL, 8'ha5);
        wr(TXL, 8'h3c);
        wr(TXL, 8'h77);
        rc(STA, 8'h00);
        chk("hresp", {31'h0, hresp}, 32'h0000_0000);
      end
    join
    repeat (3 * BT) @(posedge clk);
    rc(STA, 8'h60);
  endtask
  task automatic t_nine;
    wr(CC, 8'h07);
    wr(spdb_pkg::IDX_TXH, 8'h01);
    wr(TXL, 8'h5a);
    peer.get(fr, 9);
    chk("tx frame", {22'h0, fr}, 32'h0000_035a);
    peer.send({2'h3, 9'h1c3, 1'b0}, 11);
    rc(RXH, 8'h81);
    rc(RXL, 8'hc3);
  endtask
  // nine bits low byte first, then master spi with a bad stop bit
  task automatic t_modes;
    wr(CC, 8'h06);
    wr(TXL, 8'h5a);
    wr(spdb_pkg::IDX_TXH, 8'h01);
    peer.get(fr, 9);
    chk("tx frame", {22'h0, fr}, 32'h0000_035a);
    peer.send({2'h3, 9'h1c3, 1'b0}, 11);
    rc(RXL, 8'hc3);
    rc(RXH, 8'h81);
    rc(RXH, 8'h00);
    wr(CC, 8'hc7);
    wr(TXL, 8'h5a);
    peer.get(fr, 9);
    chk("tx frame", {22'h0, fr}, 32'h0000_025a);
    peer.send({2'h2, 9'h03c, 1'b0}, 11);
    rc(RXH, 8'h80);
    rc(RXL, 8'h3c);
  endtask
  // break, sync, identifier with bad parity, one response byte
  task automatic t_lin;
    wr(CC, 8'h03);
    wr(CB, 8'h86);
    peer.send({3'h6, 8'h00, 1'b0}, 10);
    rc(RXL, 8'h00);
    peer.send({3'h7, 8'h55, 1'b0}, 10);
    rc(RXL, 8'h55);
    peer.send({3'h7, 8'h00, 1'b0}, 10);
    rc(RXH, 8'h82);
    rc(RXL, 8'h00);
    peer.send({3'h7, 8'h11, 1'b0}, 10);
    rc(RXH, 8'h81);
    rc(RXL, 8'h11);
  endtask
  task automatic stop_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard, far above the roughly one thousand cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      stop_test;
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset;
    t_overrun;
    t_parity;
    t_short;
    t_tx;
    t_nine;
    t_modes;
    t_lin;
    stop_test;
  end
endmodule

// ===== verilog/spdb_pkg.sv
// constants for the serial port data buffers
package spdb_pkg;
  // ************************************************************
  // register indexes (byte address is four times the index)
  // ************************************************************
  localparam logic [7:0] IDX_RXL    = 8'h00;
  localparam logic [7:0] IDX_RXH    = 8'h01;
  localparam logic [7:0] IDX_TXL    = 8'h02;
  localparam logic [7:0] IDX_TXH    = 8'h03;
  localparam logic [7:0] IDX_STATUS = 8'h04;
  localparam logic [7:0] IDX_INTERRUPT_AND_MODE_CONTROL  = 8'h05;
  localparam logic [7:0] IDX_ENABLE_AND_RECEIVE_MODE_CONTROL  = 8'h06;
  localparam logic [7:0] IDX_FRAME_FORMAT_CONTROL  = 8'h07;
  localparam logic [7:0] IDX_BAUDL  = 8'h08;
  localparam logic [7:0] IDX_BAUDH  = 8'h09;
  localparam logic [7:0] IDX_AUTOBAUD_WINDOW_CONTROL  = 8'h0a;
  localparam logic [7:0] IDX_DBG    = 8'h0b;
  localparam logic [7:0] IDX_EVENT_INPUT_CONTROL = 8'h0c;
  localparam logic [7:0] IDX_TXPL   = 8'h0d;
  localparam logic [7:0] IDX_RXPL   = 8'h0e;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int ST_TXC    = 6;  // status: transmit complete, write one clears
  localparam int CB_RXEN   = 7;  // enable_and_receive_mode_control
  localparam int CB_TXEN   = 6;
  localparam int CB_RXM_LO = 1;  // receive_mode_select [2:1]
  localparam int CC_CM_LO  = 6;  // communication mode [7:6]
  localparam int CC_PM_LO  = 4;  // parity mode [5:4]
  localparam int CC_SB     = 3;  // stop_bit_count_select
  // ************************************************************
  // field values and reset values
  // ************************************************************
  localparam logic [1:0] RXM_LIN   = 2'h3;
  localparam logic [1:0] CM_MSPI   = 2'h3;
  localparam logic [2:0] CS_9L     = 3'h6;  // nine bits, low byte first
  localparam logic [2:0] CS_9H     = 3'h7;  // nine bits, high byte first
  localparam logic [7:0] RST_REG   = 8'h00;
  localparam logic [8:0] RST_CHAR  = 9'h000;
  localparam logic [1:0] LIN_SYNC  = 2'h1;  // break seen, sync next
  localparam logic [1:0] LIN_PID   = 2'h2;  // identifier next
  localparam logic [1:0] LIN_RESP  = 2'h3;  // response space
  // receiver states
  typedef enum logic [2:0] {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b010,
    RX_PAR   = 3'b011,
    RX_STOP  = 3'b100
  } spdb_rx_e;
endpackage

// ===== verilog/spdb_top.sv
// serial port data buffers: receive fifo, transmit buffer, ahb-lite registers
//
// Functional notes
// [RULE_01] receive buffer holds two entries with flags
// [RULE_02] each buffer read advances data and flags
// [RULE_03] software reads bytes in size-dependent order
// [RULE_04] receive-complete follows unread characters present
// [RULE_05] receiver disable flushes buffer, clears receive-complete
// [RULE_06] overrun: full buffer, waiting char, new start
// [RULE_07] overrun stays with entry until low read; nine-bit low-first mode holds it until the high read
// [RULE_08] framing error from first stop bit only
// [RULE_09] parity error only when parity checking enabled; lin mode flags identifier parity even with checking off
// [RULE_10] lin mode: parity checks identifier field only
// [RULE_11] lin mode: ninth bit low for identifier
// [RULE_12] otherwise ninth bit is received ninth bit
// [RULE_13] master spi: no overrun, framing, parity flags
// [RULE_14] short characters: upper bits ignored, read zero
// [RULE_15] transmit write accepted only while buffer empty
// [RULE_16] buffer moves to empty shifter, then sent
// [RULE_17] software writes ninth bit in size order
// [RULE_18] master spi: ninth transmit bit unused
// [RULE_19] low write clears empty flag, load sets
// [RULE_20] receive mode three selects lin constrained mode
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
module spdb_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // serial line
  input  wire logic        rxd,
  output logic             txd
);
  // ************************************************************
  // control registers
  // ************************************************************
  logic [7:0]  interrupt_and_mode_control, enable_and_receive_mode_control, frame_format_control, autobaud_window_control, dbgc, evc, txpl, rxpl;
  logic [15:0] baud;                    // bit time is baud+1 clocks
  wire         rxen = enable_and_receive_mode_control[spdb_pkg::CB_RXEN];
  wire         txen = enable_and_receive_mode_control[spdb_pkg::CB_TXEN];
  wire  [2:0]  csz  = frame_format_control[2:0];       // char_size_select
  wire  [1:0]  pm   = frame_format_control[spdb_pkg::CC_PM_LO +: 2];
  wire         par_en = pm[1];
  // lin constrained mode decoded from the receive mode field
  wire         lin  = enable_and_receive_mode_control[spdb_pkg::CB_RXM_LO +: 2] == spdb_pkg::RXM_LIN; // RULE_20
  wire         mspi = frame_format_control[spdb_pkg::CC_CM_LO +: 2] == spdb_pkg::CM_MSPI;
  wire         nine = csz == spdb_pkg::CS_9L || csz == spdb_pkg::CS_9H;
  wire         lbf  = csz == spdb_pkg::CS_9L;
  // data bits per character; reserved sizes act as eight
  wire  [3:0]  nbits = nine ? 4'h9 : (csz[2] ? 4'h8 : {2'b01, csz[1:0]} + 4'h5 - 4'h4);
  wire  [8:0]  dmask = 9'h1ff >> (4'h9 - nbits);

  // ************************************************************
  // bus address phase decode
  // ************************************************************
  logic       wr_v;                     // write data phase pending
  logic [7:0] wr_idx;
  wire        take  = hsel & hready & htrans[1];
  wire        mapok = haddr[1:0] == 2'b00 && haddr[31:10] == 22'h00_0000;
  wire  [7:0] a_idx = haddr[9:2];
  wire        rd_go = take & ~hwrite & mapok;
  wire        rd_lo = rd_go && a_idx == spdb_pkg::IDX_RXL;
  wire        rd_hi = rd_go && a_idx == spdb_pkg::IDX_RXH;
  wire  [7:0] wd    = hwdata[7:0];
  wire        w_txl = wr_v && wr_idx == spdb_pkg::IDX_TXL;
  wire        w_txh = wr_v && wr_idx == spdb_pkg::IDX_TXH;
  wire        w_st  = wr_v && wr_idx == spdb_pkg::IDX_STATUS;

  // ************************************************************
  // receive buffer state
  // ************************************************************
  logic [8:0] buf_d [2];
  logic       buf_fe [2], buf_pe [2], buf_ov [2];
  logic       head;
  logic [1:0] count;
  logic [8:0] pend_d;                   // character waiting in shifter
  logic       pend_v, pend_fe, pend_pe, pend_ov;
  wire        rxc   = count != 2'd0;    // RULE_04
  // reading the byte that is read last advances the buffer
  wire        pop   = (lbf ? rd_hi : rd_lo) & rxc; // RULE_02 RULE_07
  wire        push  = pend_v && count != 2'd2;
  wire        tail  = head ^ count[0];
  wire  [1:0] next_count = count + {1'b0, push} - {1'b0, pop};

  // ************************************************************
  // receiver
  // ************************************************************
  logic       rx_s1, rx_s2, rx_prev;    // synchroniser and edge history
  spdb_pkg::spdb_rx_e rx_st;
  logic [15:0] rx_cnt;
  logic [3:0]  rx_idx;
  logic [8:0]  rx_sh;
  logic        rx_pb;
  logic [1:0]  lin_pos;
  wire         fall   = rx_prev & ~rx_s2;
  wire         tick   = rx_cnt == 16'h0000;
  wire         stop_t = rx_st == spdb_pkg::RX_STOP && tick;
  wire  [8:0]  cap_dm = rx_sh & dmask;  // RULE_14
  wire         is_pid = lin && lin_pos == spdb_pkg::LIN_PID;
  // identifier parity: p0 and inverted p1 equations
  wire         pid_bad = (cap_dm[6] != (cap_dm[0] ^ cap_dm[1] ^ cap_dm[2] ^ cap_dm[4]))
                      || (cap_dm[7] != ~(cap_dm[1] ^ cap_dm[3] ^ cap_dm[4] ^ cap_dm[5]));
  wire         gen_bad = (^cap_dm ^ rx_pb) != pm[0];
  // parity flag: identifier check in lin mode, else only when enabled
  wire         cap_pe = ~mspi & (lin ? (is_pid & pid_bad) : (par_en & gen_bad)); // RULE_09 RULE_10 RULE_13
  // only the first stop bit is sampled, extra stop bits never looked at
  wire         cap_fe = ~mspi & ~rx_s2; // RULE_08 RULE_13
  // ninth bit: lin position marker, else received ninth bit
  wire         cap_b8 = lin ? ~is_pid : (nine & cap_dm[8]); // RULE_11 RULE_12
  wire         ovf_ev = rx_st == spdb_pkg::RX_IDLE && fall && rxen
                      && count == 2'd2 && pend_v && ~mspi;

  // ************************************************************
  // transmitter state
  // ************************************************************
  logic [7:0]  tx_buf;                  // tx_data_buffer low byte
  logic        tx_high;                 // ninth transmit bit
  logic        dre;                     // tx_buffer_empty_flag
  logic        tx_hold;                 // low-first: wait for ninth bit
  logic        txc;
  logic [12:0] tx_sh;
  logic [3:0]  tx_left;
  logic [15:0] tx_cnt;
  wire         tx_load = txen & ~dre & ~tx_hold & tx_left == 4'h0;
  wire         tx_tick = tx_cnt == 16'h0000;
  // ninth bit dropped in master spi and for short characters
  wire  [8:0]  tx_d9  = {tx_high & nine & ~mspi, tx_buf} & dmask; // RULE_14 RULE_18
  wire         tx_pb  = ^tx_d9 ^ pm[0];
  wire  [13:0] tx_top = par_en ? ((14'h3fff << (nbits + 4'h1)) | (14'({tx_pb}) << nbits))
                               : (14'h3fff << nbits);
  wire  [13:0] tx_fr  = {tx_top[12:0] | {4'h0, tx_d9}, 1'b0};
  wire  [3:0]  tx_len = 4'h2 + nbits + {3'h0, par_en} + {3'h0, frame_format_control[spdb_pkg::CC_SB]};
  wire         tx_end = tx_left == 4'h1 && tx_tick;

  // ************************************************************
  // read data selection
  // ************************************************************
  wire  [7:0]  rxl_v = rxc ? buf_d[head][7:0] : spdb_pkg::RST_REG;
  wire  [7:0]  rxh_v = rxc ? {1'b1, buf_ov[head], 3'b000, buf_fe[head], buf_pe[head],
                              buf_d[head][8]} : spdb_pkg::RST_REG;
  wire  [7:0]  st_v  = {rxc, txc, dre, 5'b00000};
  logic [7:0]  rsel;
  always_comb begin
    case (a_idx)
      spdb_pkg::IDX_RXL:    rsel = rxl_v;
      spdb_pkg::IDX_RXH:    rsel = rxh_v;
      spdb_pkg::IDX_TXL:    rsel = tx_buf;
      spdb_pkg::IDX_TXH:    rsel = {7'h00, tx_high};
      spdb_pkg::IDX_STATUS: rsel = st_v;
      spdb_pkg::IDX_INTERRUPT_AND_MODE_CONTROL:  rsel = interrupt_and_mode_control;
      spdb_pkg::IDX_ENABLE_AND_RECEIVE_MODE_CONTROL:  rsel = enable_and_receive_mode_control;
      spdb_pkg::IDX_FRAME_FORMAT_CONTROL:  rsel = frame_format_control;
      spdb_pkg::IDX_BAUDL:  rsel = baud[7:0];
      spdb_pkg::IDX_BAUDH:  rsel = baud[15:8];
      spdb_pkg::IDX_AUTOBAUD_WINDOW_CONTROL:  rsel = autobaud_window_control;
      spdb_pkg::IDX_DBG:    rsel = dbgc;
      spdb_pkg::IDX_EVENT_INPUT_CONTROL: rsel = evc;
      spdb_pkg::IDX_TXPL:   rsel = txpl;
      spdb_pkg::IDX_RXPL:   rsel = rxpl;
      default:              rsel = spdb_pkg::RST_REG;  // unmapped reads zero
    endcase
  end

  // ************************************************************
  // bus slave: zero wait, always okay
  // ************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_v      <= 1'b0;
      wr_idx    <= spdb_pkg::RST_REG;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      wr_v      <= take & hwrite & mapok;
      if (take) begin
        wr_idx <= a_idx;
      end
      if (rd_go) begin
        hrdata <= {24'h00_0000, rsel};
      end
    end
  end

  // plain control registers, written in the data phase
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {interrupt_and_mode_control, enable_and_receive_mode_control, frame_format_control, autobaud_window_control} <= {4{spdb_pkg::RST_REG}};
      {dbgc, evc, txpl, rxpl}      <= {4{spdb_pkg::RST_REG}};
      baud                         <= 16'h0000;
    end else if (wr_v) begin
      case (wr_idx)
        spdb_pkg::IDX_INTERRUPT_AND_MODE_CONTROL:  interrupt_and_mode_control      <= wd;
        spdb_pkg::IDX_ENABLE_AND_RECEIVE_MODE_CONTROL:  enable_and_receive_mode_control      <= wd;
        spdb_pkg::IDX_FRAME_FORMAT_CONTROL:  frame_format_control      <= wd;
        spdb_pkg::IDX_BAUDL:  baud[7:0]  <= wd;
        spdb_pkg::IDX_BAUDH:  baud[15:8] <= wd;
        spdb_pkg::IDX_AUTOBAUD_WINDOW_CONTROL:  autobaud_window_control      <= wd;
        spdb_pkg::IDX_DBG:    dbgc       <= wd;
        spdb_pkg::IDX_EVENT_INPUT_CONTROL: evc        <= wd;
        spdb_pkg::IDX_TXPL:   txpl       <= wd;
        spdb_pkg::IDX_RXPL:   rxpl       <= {1'b0, wd[6:0]};
        default:              interrupt_and_mode_control      <= interrupt_and_mode_control;
      endcase
    end
  end

  // ************************************************************
  // receiver sampling machine
  // ************************************************************
  // samples mid-bit; a start bit high at mid-bit is a false start
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {rx_s1, rx_s2, rx_prev} <= 3'b111;
      rx_st  <= spdb_pkg::RX_IDLE;
      rx_cnt <= 16'h0000;
      rx_idx <= 4'h0;
      rx_sh  <= spdb_pkg::RST_CHAR;
      rx_pb  <= 1'b0;
    end else begin
      rx_s1   <= rxd;
      rx_s2   <= rx_s1;
      rx_prev <= rx_s2;
      rx_cnt  <= tick ? baud : rx_cnt - 16'h0001;
      case (rx_st)
        spdb_pkg::RX_IDLE: begin
          if (rxen && fall) begin
            rx_st  <= spdb_pkg::RX_START;
            rx_cnt <= {1'b0, baud[15:1]};
          end
        end
        spdb_pkg::RX_START: begin
          if (tick) begin
            rx_st  <= rx_s2 ? spdb_pkg::RX_IDLE : spdb_pkg::RX_DATA;
            rx_idx <= 4'h0;
            rx_sh  <= spdb_pkg::RST_CHAR;
          end
        end
        spdb_pkg::RX_DATA: begin
          if (tick) begin
            rx_sh[rx_idx] <= rx_s2;
            rx_idx        <= rx_idx + 4'h1;
            if (rx_idx == nbits - 4'h1) begin
              rx_st <= (par_en && !lin) ? spdb_pkg::RX_PAR : spdb_pkg::RX_STOP;
            end
          end
        end
        spdb_pkg::RX_PAR: begin
          if (tick) begin
            rx_pb <= rx_s2;
            rx_st <= spdb_pkg::RX_STOP;
          end
        end
        spdb_pkg::RX_STOP: begin
          if (tick) begin
            rx_st <= spdb_pkg::RX_IDLE;
          end
        end
        default: rx_st <= spdb_pkg::RX_IDLE;
      endcase
      if (!rxen) begin
        rx_st <= spdb_pkg::RX_IDLE;
      end
    end
  end

  // ************************************************************
  // waiting character, lin position and two-entry buffer
  // ************************************************************
  // a character finishing while another still waits is dropped; the
  // waiting one keeps its place and carries the overrun mark
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend_v  <= 1'b0;
      pend_d  <= spdb_pkg::RST_CHAR;
      {pend_fe, pend_pe, pend_ov} <= 3'b000;
      lin_pos <= spdb_pkg::LIN_RESP;
      head    <= 1'b0;
      count   <= 2'd0;
    end else if (!rxen) begin
      pend_v  <= 1'b0;                  // RULE_05
      pend_ov <= 1'b0;
      count   <= 2'd0;                  // RULE_05
      lin_pos <= spdb_pkg::LIN_RESP;
    end else begin
      count <= next_count;              // RULE_01
      head  <= head ^ pop;
      if (ovf_ev) begin
        pend_ov <= 1'b1;                // RULE_06
      end
      if (push) begin
        pend_v  <= 1'b0;
        pend_ov <= 1'b0;
      end
      if (stop_t && (!pend_v || push)) begin
        pend_v  <= 1'b1;
        pend_d  <= {cap_b8, cap_dm[7:0]};
        pend_fe <= cap_fe;
        pend_pe <= cap_pe;
      end
      // a zero character with a bad stop bit is a break
      if (stop_t) begin
        if (~rx_s2 && cap_dm == 9'h000) begin
          lin_pos <= spdb_pkg::LIN_SYNC;
        end else if (lin_pos != spdb_pkg::LIN_RESP) begin
          lin_pos <= lin_pos + 2'd1;
        end
      end
    end
  end

  // one write port per entry; each entry keeps its own flags
  for (genvar e = 0; e < 2; e++) begin : g_ent
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        buf_d[e]  <= spdb_pkg::RST_CHAR;
        buf_fe[e] <= 1'b0;
        buf_pe[e] <= 1'b0;
        buf_ov[e] <= 1'b0;
      end else if (push && rxen && tail == 1'(e)) begin
        buf_d[e]  <= pend_d;            // RULE_01
        buf_fe[e] <= pend_fe;
        buf_pe[e] <= pend_pe;
        buf_ov[e] <= pend_ov;           // RULE_07
      end
    end
  end

  // ************************************************************
  // transmit buffer and shifter
  // ************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_buf  <= spdb_pkg::RST_REG;
      tx_high <= 1'b0;
      dre     <= 1'b1;
      tx_hold <= 1'b0;
      txc     <= 1'b0;
      tx_sh   <= 13'h1fff;
      tx_left <= 4'h0;
      tx_cnt  <= 16'h0000;
      txd     <= 1'b1;
    end else begin
      // low-byte writes while the buffer is full are dropped
      if (w_txl && dre) begin
        tx_buf  <= wd;                  // RULE_15
        dre     <= 1'b0;                // RULE_19
        tx_hold <= lbf;
      end
      if (w_txh) begin
        tx_high <= wd[0];
        tx_hold <= 1'b0;
      end
      // shifter empty: take the buffer at once
      if (tx_load) begin
        tx_sh   <= tx_fr[12:0];         // RULE_16
        tx_left <= tx_len;
        tx_cnt  <= baud;
        dre     <= 1'b1;                // RULE_19
      end else if (tx_left != 4'h0) begin
        tx_cnt <= tx_tick ? baud : tx_cnt - 16'h0001;
        if (tx_tick) begin
          tx_sh   <= {1'b1, tx_sh[12:1]};
          tx_left <= tx_left - 4'h1;
        end
      end
      // set wins over a clear in the same cycle
      if (tx_end && dre) begin
        txc <= 1'b1;
      end else if (w_st && wd[spdb_pkg::ST_TXC]) begin
        txc <= 1'b0;
      end
      txd <= (tx_left != 4'h0) ? tx_sh[0] : 1'b1;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  property p_depth;
    @(posedge clk) disable iff (!nrst) count <= 2'd2;
  endproperty
  a_depth: assert property (p_depth) else $error("buffer count above two"); // RULE_01

  property p_pop;
    @(posedge clk) disable iff (!nrst)
      (pop && !push && rxen) |=> count == $past(count) - 2'd1;
  endproperty
  a_pop: assert property (p_pop) else $error("read did not advance buffer"); // RULE_02

  property p_rxc_clear;
    @(posedge clk) disable iff (!nrst)
      (count == 2'd1 && pop && !push && rxen) |=> !rxc ##1 (!rxc || $past(push));
  endproperty
  a_rxc_clear: assert property (p_rxc_clear) else $error("flag stuck after last read"); // RULE_04

  property p_flush;
    @(posedge clk) disable iff (!nrst) !rxen |=> count == 2'd0 && !pend_v;
  endproperty
  a_flush: assert property (p_flush) else $error("disable did not flush"); // RULE_05

  property p_ovf;
    @(posedge clk) disable iff (!nrst) (ovf_ev && !push) |=> pend_ov;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overrun not flagged"); // RULE_06

  property p_par_off;
    @(posedge clk) disable iff (!nrst)
      (stop_t && rxen && !pend_v && !par_en && !lin) |=> pend_v && !pend_pe;
  endproperty
  a_par_off: assert property (p_par_off) else $error("parity flag without checking"); // RULE_09

  property p_lin_pid;
    @(posedge clk) disable iff (!nrst)
      (stop_t && rxen && !pend_v && is_pid) |=> pend_v && !pend_d[8];
  endproperty
  a_lin_pid: assert property (p_lin_pid) else $error("identifier ninth bit not low"); // RULE_11

  property p_spi_flags;
    @(posedge clk) disable iff (!nrst)
      (stop_t && rxen && !pend_v && mspi) |=> !pend_fe && !pend_pe;
  endproperty
  a_spi_flags: assert property (p_spi_flags) else $error("error flag in master spi"); // RULE_13

  property p_drop;
    @(posedge clk) disable iff (!nrst) (w_txl && !dre) |=> tx_buf == $past(tx_buf);
  endproperty
  a_drop: assert property (p_drop) else $error("write taken while buffer full"); // RULE_15

  property p_load;
    @(posedge clk) disable iff (!nrst)
      tx_load |=> dre && tx_left == $past(tx_len) ##1 (tx_left != 4'h0) && !txd;
  endproperty
  a_load: assert property (p_load) else $error("buffer not moved to shifter"); // RULE_16

  property p_dre_clr;
    @(posedge clk) disable iff (!nrst) (w_txl && dre && !tx_load) |=> !dre;
  endproperty
  a_dre_clr: assert property (p_dre_clr) else $error("empty flag not cleared"); // RULE_19

  c_two: cover property (@(posedge clk) disable iff (!nrst) count == 2'd2);
  c_ovf: cover property (@(posedge clk) disable iff (!nrst) ovf_ev);
  c_txc: cover property (@(posedge clk) disable iff (!nrst) tx_end && dre);
endmodule
